// file: pkg/ckd_pkg.sv
// Package for the CORDIC kernel datapath: register map, fields, widths, tables.
package ckd_pkg;
    localparam int DATA_W   = 16;
    localparam int XY_W     = 26;
    localparam int Z_W      = 21;
    localparam int ITER_N   = 16;
    localparam int LIN_W    = 16;
    localparam int LAT_MAX  = 41;

    localparam logic [7:0] OFF_XDATA  = 8'h00;
    localparam logic [7:0] OFF_YDATA  = 8'h04;
    localparam logic [7:0] OFF_ZDATA  = 8'h08;
    localparam logic [7:0] OFF_STATC  = 8'h0c;
    localparam logic [7:0] OFF_CON    = 8'h10;
    localparam logic [7:0] OFF_PMC    = 8'h14;

    localparam int STAT_BSY   = 0;
    localparam int STAT_ERR   = 1;
    localparam int STAT_EOC   = 2;
    localparam int STAT_DMAP  = 4;
    localparam int STAT_KEEPX = 5;
    localparam int STAT_KEEPY = 6;
    localparam int STAT_KEEPZ = 7;

    localparam int CON_ST     = 0;
    localparam int CON_MODE   = 1;
    localparam int CON_ROTVEC = 3;
    localparam int CON_STMODE = 4;
    localparam int CON_XUNS   = 5;
    localparam int CON_MPS    = 6;
    localparam int PMC_CLKOFF = 6;

    localparam logic [7:0] CON_RESET  = 8'h62;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [1:0] MODE_LIN   = 2'h0;
    localparam logic [1:0] MODE_CIRC  = 2'h1;
    localparam logic [1:0] MODE_HYP   = 2'h3;
    localparam logic [1:0] MPS_KEEP   = 2'h3;
    localparam logic [LIN_W-1:0] LIN_INIT = 16'h8000;

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PRE, S_ITER, S_POST, S_DONE} ckd_state_type;

    function automatic logic [19:0] ckd_atan(input logic [3:0] i);
        logic [19:0] t;
        t = 20'h00000;
        unique case (i)
            4'h0: t = 20'h20000;  4'h1: t = 20'h12e40;  4'h2: t = 20'h09fb4;
            4'h3: t = 20'h05111;  4'h4: t = 20'h028b1;  4'h5: t = 20'h0145d;
            4'h6: t = 20'h00a2f;  4'h7: t = 20'h00518;  4'h8: t = 20'h0028c;
            4'h9: t = 20'h00146;  4'ha: t = 20'h000a3;  4'hb: t = 20'h00051;
            4'hc: t = 20'h00029;  4'hd: t = 20'h00014;  4'he: t = 20'h0000a;
            4'hf: t = 20'h00005;
        endcase
        return t;
    endfunction

    // Bit 20 flags an iteration that runs twice (steps 4 and 13).
    function automatic logic [20:0] ckd_atanh(input logic [3:0] i);
        logic [20:0] t;
        t = 21'h000000;
        unique case (i)
            4'h0: t = 21'h000000; 4'h1: t = 21'h016618; 4'h2: t = 21'h00a681;
            4'h3: t = 21'h0051ea; 4'h4: t = 21'h1028cc; 4'h5: t = 21'h001461;
            4'h6: t = 21'h000a30; 4'h7: t = 21'h000518; 4'h8: t = 21'h00028c;
            4'h9: t = 21'h000146; 4'ha: t = 21'h0000a3; 4'hb: t = 21'h000051;
            4'hc: t = 21'h000029; 4'hd: t = 21'h100014; 4'he: t = 21'h00000a;
            4'hf: t = 21'h000005;
        endcase
        return t;
    endfunction
endpackage

// file: hw/ckd_top.sv
// CORDIC kernel datapath with its APB register slave.
// Summary of operation
// - Inputs and results are two's complement.
// - Unsigned X only in circular vectoring.
// - Linear Z visible as S4.11.
// - Sixteen iterations, circular/linear start at zero.
// - Hyperbolic starts at one, repeats flagged steps.
// - Data 16 bits, XY 26, Z 21.
// - Calculation finishes within 41 cycles.
// - Error valid one cycle after end.
// - Barrel shift X, Y; shift-register linear table.
// - Combinational tables, muxed, added by direction.
// - Linear table reloaded on setup state.
// - Atan entry: sign plus 19-bit magnitude.
// - Atanh entry: repeat, sign, 19 bits.
// - Atan table holds listed constants.
// - Atanh table holds listed constants, none at zero.
// - Angle Z read drops four LSBs.
// - Linear table starts at one, halves.
// - Linear Z 4Q15, reads drop four bits.
// - Clock-off request halts the coprocessor.
// - Clock-off is power register bit six.
// - Prescale X, Y after last iteration.
`timescale 1ns/1ps
module ckd_top
    import ckd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy,
    output logic             end_of_calc
);
    logic [DATA_W-1:0] x_shadow_reg, y_shadow_reg, z_shadow_reg;
    logic [7:0]        con_reg, statc_reg, pmc_reg;
    logic [XY_W-1:0]   x_reg, y_reg;
    logic [Z_W-1:0]    z_reg;
    logic [LIN_W-1:0]  lin_reg;
    logic [3:0]        iter_reg;
    logic              rep_done_reg, neg_pre_reg, err_pend_reg;
    logic [1:0]        mps_reg;
    ckd_state_type     state_reg;

    wire access   = psel && penable;
    wire wr       = access && pwrite;
    wire rd       = access && !pwrite;
    wire clk_off  = pmc_reg[PMC_CLKOFF];
    wire [1:0] mode = con_reg[CON_MODE +: 2];
    wire rotation = con_reg[CON_ROTVEC];
    wire running  = state_reg != S_IDLE;
    wire start_req = !running && !clk_off &&
                     ((wr && paddr == OFF_XDATA && !con_reg[CON_STMODE]) ||
                      (con_reg[CON_ST] && con_reg[CON_STMODE]));

    // Direction: rotation drives Z to zero, vectoring drives Y to zero.
    wire dir_neg = rotation ? z_reg[Z_W-1] : !y_reg[XY_W-1];

    function automatic logic [XY_W-1:0] sshift(input logic [XY_W-1:0] v, input logic [3:0] n);
        return XY_W'($signed(v) >>> n);
    endfunction

    function automatic logic [XY_W-1:0] ext16(input logic [DATA_W-1:0] v);
        return {{2{v[15]}}, v, 8'h00};
    endfunction

    // Table entries go through nets, as a function result cannot be bit-selected.
    wire [19:0] atan_entry  = ckd_atan(iter_reg);
    wire [20:0] atanh_entry = ckd_atanh(iter_reg);

    // Z table entry: sign-extended atan/atanh, or the linear table with its one at Z bit 15.
    logic [Z_W-1:0] z_step;
    always_comb
    begin
        z_step = '0;
        unique case (mode)
            MODE_LIN:  z_step = {5'h00, lin_reg};
            MODE_HYP:  z_step = {atanh_entry[19], atanh_entry[19:0]};
            default:   z_step = {atan_entry[19], atan_entry};
        endcase
    end

    wire [XY_W-1:0] xs = sshift(x_reg, iter_reg);
    wire [XY_W-1:0] ys = sshift(y_reg, iter_reg);
    wire [XY_W-1:0] x_lin = x_reg;
    wire [XY_W-1:0] x_circ = dir_neg ? x_reg + ys : x_reg - ys;
    wire [XY_W-1:0] x_hyp  = dir_neg ? x_reg - ys : x_reg + ys;
    // Every function moves Y by X * 2^-i; only X and Z differ between functions.
    wire [XY_W-1:0] y_new  = dir_neg ? y_reg - xs : y_reg + xs;
    wire [Z_W-1:0]  z_new  = dir_neg ? z_reg + z_step : z_reg - z_step;
    wire last_iter = iter_reg == 4'(ITER_N - 1);
    wire repeat_now = (mode == MODE_HYP) && atanh_entry[20] && !rep_done_reg;

    function automatic logic [XY_W-1:0] prescale(input logic [XY_W-1:0] v, input logic [1:0] m);
        return (m == 2'h2) ? sshift(v, 4'h2) : (m == 2'h1) ? sshift(v, 4'h1) : v;
    endfunction

    function automatic logic ovf16(input logic [XY_W-1:0] v, input logic uns);
        return uns ? (v[25] || v[24]) : (v[25] != v[23] || v[24] != v[23]);
    endfunction

    // Calculation sequencer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= S_IDLE;
            iter_reg     <= 4'h0;
            rep_done_reg <= 1'b0;
            neg_pre_reg  <= 1'b0;
            lin_reg      <= LIN_INIT;
            x_reg        <= '0;
            y_reg        <= '0;
            z_reg        <= '0;
        end
        else if (!clk_off)
        begin
            unique case (state_reg)
                S_IDLE:
                begin
                    if (start_req)
                        state_reg <= S_SETUP;
                end
                S_SETUP:
                begin
                    lin_reg      <= LIN_INIT;
                    rep_done_reg <= 1'b0;
                    iter_reg     <= (mode == MODE_HYP) ? 4'h1 : 4'h0;
                    neg_pre_reg  <= 1'b0;
                    if (!statc_reg[STAT_KEEPX]) x_reg <= ext16(x_shadow_reg);
                    if (!statc_reg[STAT_KEEPY]) y_reg <= ext16(y_shadow_reg);
                    if (!statc_reg[STAT_KEEPZ])
                        z_reg <= {z_shadow_reg[15], z_shadow_reg, 4'h0};
                    state_reg <= (mode == MODE_CIRC) ? S_PRE : S_ITER;
                end
                S_PRE:
                begin
                    // Fold into the right half-plane so full-range inputs converge.
                    if (rotation && (z_reg[20:18] == 3'b001 || z_reg[20:18] == 3'b110))
                    begin
                        z_reg <= z_reg ^ 21'h180000;
                        neg_pre_reg <= 1'b1;
                    end
                    else if (!rotation && x_reg[XY_W-1])
                    begin
                        // Vectoring only converges for X > 0, so turn the vector by pi first.
                        x_reg <= -x_reg;
                        y_reg <= -y_reg;
                        z_reg <= z_reg + 21'h080000;
                    end
                    state_reg <= S_ITER;
                end
                S_ITER:
                begin
                    x_reg <= (mode == MODE_LIN) ? x_lin :
                             (mode == MODE_HYP) ? x_hyp : x_circ;
                    y_reg <= y_new;
                    z_reg <= z_new;
                    if (repeat_now)
                        rep_done_reg <= 1'b1;
                    else
                    begin
                        rep_done_reg <= 1'b0;
                        lin_reg      <= lin_reg >> 1;
                        iter_reg     <= iter_reg + 4'h1;
                        if (last_iter)
                            state_reg <= S_POST;
                    end
                end
                S_POST:
                begin
                    x_reg <= prescale(neg_pre_reg ? -x_reg : x_reg, mps_reg);
                    y_reg <= prescale(neg_pre_reg ? -y_reg : y_reg, mps_reg);
                    state_reg <= S_DONE;
                end
                S_DONE:
                    state_reg <= S_IDLE;
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    wire x_uns = con_reg[CON_XUNS] && mode == MODE_CIRC && !rotation;
    wire err_now = ovf16(x_reg, x_uns) || ovf16(y_reg, 1'b0) || (z_reg[20] != z_reg[19]);

    // Control and status registers; hardware set wins over a clearing read.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            con_reg      <= CON_RESET;
            statc_reg    <= STAT_RESET;
            pmc_reg      <= 8'h00;
            mps_reg      <= CON_RESET[CON_MPS +: 2];
            err_pend_reg <= 1'b0;
        end
        else
        begin
            if (wr && paddr == OFF_PMC)
                pmc_reg <= {1'b0, pwdata[6:0]};
            if (wr && paddr == OFF_CON && !running)
            begin
                con_reg <= pwdata[7:0];
                if (pwdata[7:6] != MPS_KEEP)
                    mps_reg <= pwdata[7:6];
            end
            else if (state_reg == S_SETUP)
                con_reg[CON_ST] <= 1'b0;
            if (wr && paddr == OFF_STATC)
                statc_reg[7:3] <= pwdata[7:3];
            if (wr && paddr == OFF_STATC && !pwdata[STAT_EOC])
                statc_reg[STAT_EOC] <= 1'b0;
            if (rd && paddr == OFF_STATC)
                statc_reg[STAT_ERR] <= 1'b0;
            if (rd && paddr == OFF_ZDATA && !statc_reg[STAT_DMAP])
                statc_reg[STAT_EOC] <= 1'b0;
            statc_reg[STAT_BSY] <= running && state_reg != S_DONE;
            err_pend_reg <= 1'b0;
            if (state_reg == S_SETUP)
                statc_reg[STAT_ERR] <= 1'b0;
            if (state_reg == S_DONE && !clk_off)
            begin
                statc_reg[STAT_EOC] <= 1'b1;
                err_pend_reg        <= err_now;
            end
            if (err_pend_reg)
                statc_reg[STAT_ERR] <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            x_shadow_reg <= '0;
            y_shadow_reg <= '0;
            z_shadow_reg <= '0;
        end
        else if (wr)
        begin
            if (paddr == OFF_XDATA) x_shadow_reg <= pwdata[15:0];
            if (paddr == OFF_YDATA) y_shadow_reg <= pwdata[15:0];
            if (paddr == OFF_ZDATA) z_shadow_reg <= pwdata[15:0];
        end
    end

    // Read path and APB answer, no wait state.
    logic [31:0] rd_next;
    always_comb
    begin
        rd_next = 32'h00000000;
        unique case (paddr)
            OFF_XDATA: rd_next[15:0] = statc_reg[STAT_DMAP] ? x_shadow_reg : x_reg[23:8];
            OFF_YDATA: rd_next[15:0] = statc_reg[STAT_DMAP] ? y_shadow_reg : y_reg[23:8];
            OFF_ZDATA: rd_next[15:0] = statc_reg[STAT_DMAP] ? z_shadow_reg : z_reg[19:4];
            OFF_STATC: rd_next[7:0]  = statc_reg;
            OFF_CON:   rd_next[7:0]  = con_reg;
            OFF_PMC:   rd_next[7:0]  = pmc_reg;
            default:   rd_next = 32'h00000000;
        endcase
    end

    wire mapped = paddr == OFF_XDATA || paddr == OFF_YDATA || paddr == OFF_ZDATA ||
                  paddr == OFF_STATC || paddr == OFF_CON || paddr == OFF_PMC;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata      <= 32'h00000000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            busy        <= 1'b0;
            end_of_calc <= 1'b0;
        end
        else
        begin
            pready      <= psel && !penable;
            pslverr     <= psel && !penable && !mapped;
            prdata      <= (psel && !penable && !pwrite) ? rd_next : 32'h00000000;
            busy        <= statc_reg[STAT_BSY];
            end_of_calc <= statc_reg[STAT_EOC];
        end
    end
endmodule

// file: test/ckd_props.sv
// Concurrent checks on the ports of the CORDIC kernel datapath.
`timescale 1ns/1ps
module ckd_props
    import ckd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy,
    input wire logic        end_of_calc
);
    localparam int CALC_BOUND = LAT_MAX;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_calc_start;
        $rose(busy);
    endsequence
    AST_READY_NEXT: assert property (s_setup |=> pready)
        else $error("no answer in the cycle after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_UNMAPPED_ERR: assert property (s_setup ##0 (paddr > OFF_PMC) |=> pready && pslverr)
        else $error("unmapped address not refused");
    AST_MAPPED_OK: assert property (s_setup ##0 (paddr <= OFF_PMC && paddr[1:0] == 2'b00)
        |=> !pslverr)
        else $error("mapped address refused");
    AST_ERR_DATA_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_CALC_BOUND: assert property (s_calc_start |-> ##[1:CALC_BOUND] !busy)
        else $error("calculation ran too long");
    AST_EOC_AT_END: assert property ($fell(busy) |-> ##[0:2] end_of_calc)
        else $error("end flag missing after calculation");
endmodule
bind ckd_top ckd_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .end_of_calc(end_of_calc));

// file: test/ckd_apb_host.sv
// Register bus master standing in for the host processor.
`timescale 1ns/1ps
module ckd_apb_host
    import ckd_pkg::*;
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // The idle cycle at the end keeps two transfers from assigning psel in one time step.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rdat, output logic fault);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rdat = prdata;
        fault = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// file: test/testbench.sv
// Self-checking testbench for the CORDIC kernel datapath.
`timescale 1ns/1ps
module testbench;
    import ckd_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel, penable, pwrite, pready, pslverr, busy, end_of_calc, e, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] xr, yr, zr;
    int          err_total;
    int          check_count;

    ckd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busy(busy), .end_of_calc(end_of_calc));
    ckd_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic end_of_test;
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Iterative results may miss the exact value by a few counts of truncation.
    task automatic near(input logic [15:0] seen, input logic [15:0] exp, input int tol);
        logic [15:0] d;
        logic [15:0] n;
        d = seen - exp;
        n = exp - seen;
        check({16'h0, seen},
              (!$isunknown(seen) && (d <= tol || n <= tol)) ? {16'h0, seen} : {16'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q, e);
    endtask

    // X and Y are given as plain integers of the same form, except X is unsigned when con sets CON_XUNS in circular vectoring.
    task automatic run(input logic [7:0] con, input logic [15:0] x, y, z);
        int n;
        wr(OFF_CON, {24'h0, con});
        wr(OFF_STATC, 32'h0);
        wr(OFF_YDATA, {16'h0, y});
        wr(OFF_ZDATA, {16'h0, z});
        wr(OFF_XDATA, {16'h0, x});
        n = 1;
        while (end_of_calc !== 1'b1 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        check(n <= LAT_MAX + 1, 1'b1);
        @(posedge pclk);
        rd(OFF_STATC);
        er = q[STAT_ERR];
        rd(OFF_XDATA);
        xr = q[15:0];
        rd(OFF_YDATA);
        yr = q[15:0];
        rd(OFF_ZDATA);
        zr = q[15:0];
    endtask

    task automatic t_reset;
        rd(OFF_CON);
        check(q, {24'h0, CON_RESET});
        rd(OFF_PMC);
        check(q, 32'h0);
        rd(8'h20);
        check({q, e}, 33'h1);
    endtask

    task automatic t_prescale;
        logic [15:0] exp;
        exp = 16'h0400;
        for (int m = 0; m < 4; m++)
        begin
            if (m < 3)
                exp = 16'h1000 >> m;
            run({m[1:0], 6'h08}, 16'h1000, 16'h0000, 16'h0000);
            check(xr, exp);
            check(er, 1'b0);
        end
    endtask

    task automatic t_linear;
        run(8'h00, 16'h1000, 16'h0800, 16'h0000);
        near(zr, 16'h0400, 2);
        check(xr, 16'h1000);
        run(8'h00, 16'h1000, 16'hf800, 16'h0000);
        near(zr, 16'hfc00, 2);
    endtask

    task automatic t_angle;
        run(8'h42, 16'h1000, 16'h1000, 16'h0000);
        near(zr, 16'h2000, 2);
        run(8'h46, 16'h1000, 16'h0800, 16'h0000);
        near(zr, 16'h1661, 3);
        run(8'h62, 16'h7000, 16'h7000, 16'h0000);
        check(er, 1'b0);
        near(xr, 16'h826b, 8);
        run(8'h42, 16'h7000, 16'h7000, 16'h0000);
        check(er, 1'b1);
    endtask

    task automatic t_overflow;
        run(8'h00, 16'h1000, 16'h1800, 16'h7f00);
        check(er, 1'b1);
        rd(OFF_STATC);
        check(q[STAT_ERR], 1'b0);
    endtask

    task automatic t_clock_off;
        logic seen;
        seen = 1'b0;
        wr(OFF_PMC, 32'h40);
        rd(OFF_PMC);
        check(q, 32'h40);
        wr(OFF_XDATA, 32'h1000);
        repeat (50)
        begin
            @(posedge pclk);
            seen = seen | busy;
        end
        check(seen, 1'b0);
        wr(OFF_PMC, 32'h0);
        repeat (50) @(posedge pclk);
        run(8'h08, 16'h1000, 16'h0000, 16'h0000);
        check(xr, 16'h1000);
    endtask

    initial
    begin
        err_total = 0;
        check_count = 0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_prescale;
        t_linear;
        t_angle;
        t_overflow;
        t_clock_off;
        end_of_test;
    end

    initial
    begin
        #200000;
        err_total++;
        end_of_test;
    end
endmodule
